/* hdl/pltc_regs.vh */
// register offsets, field positions and reset values of the phy test control bank
`ifndef PLTC_REGS_VH
`define PLTC_REGS_VH
`define PLTC_OFS_TEST_A 12'h224
`define PLTC_OFS_TEST_B 12'h228
`define PLTC_OFS_SAFETY 12'h22C
`define PLTC_A_TIMER_LSB 0
`define PLTC_A_SKIP_BIT 8
`define PLTC_A_IGNCR_BIT 9
`define PLTC_A_ANALOG_BIT 10
`define PLTC_B_NES_LSB 8
`define PLTC_B_PAR_LSB 16
`define PLTC_B_UTP_LSB 24
`define PLTC_S_UPCFG_BIT 6
`define PLTC_A_RST 32'h00000000
`define PLTC_B_RST 32'h00000000
`define PLTC_S_RST 32'hF0000000
`define PLTC_A_WMASK 32'h000FFF0F
`define PLTC_B_WMASK 32'hFF0F0FFF
`define PLTC_S_WMASK 32'hFFFFFFFF
`define PLTC_SKIP_FORCED_SYMBOLS 9'h100
`endif

/* hdl/pltc_reg_word.v */
// one masked 32-bit control register with load and write paths
`timescale 1ns/100ps
`default_nettype none
module pltc_reg_word #(
	parameter [31:0] RST_VAL = 32'h00000000,
	parameter [31:0] WMASK = 32'hFFFFFFFF
) (
	input wire clk_sys_i,
	input wire sys_rst_i,
	input wire wr_i,
	input wire [31:0] wdata_i,
	output reg [31:0] value_o
);
	// write-protected bits keep their value; reserved bits stay at reset
	always @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
			value_o <= RST_VAL;
		else if (wr_i)
			value_o <= (value_o & ~WMASK) | (wdata_i & WMASK);
	end
endmodule // pltc_reg_word
`default_nettype wire

/* hdl/pltc_phy_test_ctrl.v */
// phy test mode control register bank of one switch station
//
// Summary of operation
// RULE1: per-port bits 0..3 shrink that port's training timers to microsecond scale.
// RULE2: bit 8 forces skip sets every 256 symbols on all ports.
// RULE3: bit 9 makes receivers ignore the compliance receive training control bit.
// RULE4: bit 10 clear: two loopback-only TS1 sets make the port a digital slave.
// RULE5: digital loopback codec follows speed: 8b/10b gen1/2, 128b/130b gen3.
// RULE6: bit 10 set: slaves loop before the elastic buffer, recovered clock.
// RULE7: second register bits 8..11 enable near-end serial loop per port.
// RULE8: bits 16..19 enable parallel loop; analog bit picks interface or far-end point.
// RULE9: bits 24..31 enable user pattern per lane pair as far-end loop master.
// RULE10: pattern bits ascend quad 0 lower through quad 3 upper pair.
// RULE11: software enables patterns only as master or held in quiet detect.
// RULE12: software sets pattern-alignment bypass for wide master with separate-clock slave.
// RULE13: safety bit 6 stops every port advertising upconfigure capability.
// RULE14: one copy per station; per-port bits serve that station's four ports.
// RULE15: software preserves reserved and factory-test fields when writing.
`timescale 1ns/100ps
`default_nettype none
`include "pltc_regs.vh"
module pltc_phy_test_ctrl #(
	parameter NPORT = 4,
	parameter NPAIR = 8
) (
	// clock and synchronous reset from the switch core
	input wire clk_sys_i,
	input wire sys_rst_i,
	// management register port
	input wire reg_wr_i,
	input wire reg_rd_i,
	input wire [11:0] reg_addr_i,
	input wire [31:0] reg_wdata_i,
	output reg [31:0] reg_rdata_o,
	// training and ordered-set test controls
	output wire [NPORT-1:0] timer_test_mode_o,
	output wire skip_forced_o,
	output wire [8:0] skip_forced_symbols_o,
	output wire ignore_compliance_rx_o,
	// loopback slave tracking, same clock as the training logic
	input wire [NPORT-1:0] ts1_loopback_only_i,
	input wire [NPORT-1:0] port_is_gen3_i,
	input wire [NPORT-1:0] loop_slave_exit_i,
	output reg [NPORT-1:0] digital_loop_slave_o,
	output reg [NPORT-1:0] analog_loop_slave_o,
	output reg [NPORT-1:0] loop_codec_128b_o,
	// near-end and parallel loopback path enables
	output wire [NPORT-1:0] near_end_serial_loop_o,
	output wire [NPORT-1:0] phy_interface_loop_point_o,
	output wire [NPORT-1:0] far_end_loop_point_o,
	// user pattern gating per lane pair
	input wire [NPAIR-1:0] pair_loop_master_i,
	output wire [NPAIR-1:0] user_pattern_generator_o,
	// capability advertised in training sets
	output wire upconfig_advertise_o
);
	// register words as held by the three bank instances
	wire [31:0] test_a;
	wire [31:0] test_b;
	wire [31:0] safety;

	// address decode and write enables of the register port
	wire sel_test_a;
	wire sel_test_b;
	wire sel_safety;
	wire wr_test_a;
	wire wr_test_b;
	wire wr_safety;
	reg [31:0] rdata_d;

	// loopback slave tracking per port
	reg [NPORT-1:0] ts1_seen_q;
	reg [NPORT-1:0] digital_slave_d;
	reg [NPORT-1:0] analog_slave_d;
	reg [NPORT-1:0] codec_128b_d;
	wire [NPORT-1:0] slave_active;
	wire [NPORT-1:0] slave_entry;
	wire analog_sel;
	integer i;

	// full 12-bit compare, so aliases of the three offsets stay unmapped
	function hit;
		input [11:0] a;
		input [11:0] ofs;
		begin
			hit = (a == ofs);
		end
	endfunction

	// one strobe per register; an unmapped write raises none of them
	assign sel_test_a = hit(reg_addr_i, `PLTC_OFS_TEST_A);
	assign sel_test_b = hit(reg_addr_i, `PLTC_OFS_TEST_B);
	assign sel_safety = hit(reg_addr_i, `PLTC_OFS_SAFETY);
	assign wr_test_a = reg_wr_i & sel_test_a;
	assign wr_test_b = reg_wr_i & sel_test_b;
	assign wr_safety = reg_wr_i & sel_safety;

	// one copy of each register per station instance
	pltc_reg_word #(.RST_VAL(`PLTC_A_RST), .WMASK(`PLTC_A_WMASK)) u_test_a ( // RULE14
		.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i),
		.wr_i(wr_test_a),
		.wdata_i(reg_wdata_i),
		.value_o(test_a)
	);

	// reserved and factory bits of the second word are masked off too
	pltc_reg_word #(.RST_VAL(`PLTC_B_RST), .WMASK(`PLTC_B_WMASK)) u_test_b (
		.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i),
		.wr_i(wr_test_b),
		.wdata_i(reg_wdata_i),
		.value_o(test_b)
	);

	// every safety bit is writable; only bit 6 leaves the bank
	pltc_reg_word #(.RST_VAL(`PLTC_S_RST), .WMASK(`PLTC_S_WMASK)) u_safety (
		.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i),
		.wr_i(wr_safety),
		.wdata_i(reg_wdata_i),
		.value_o(safety)
	);

	// read mux; unmapped offsets read zero, no read keeps the last word
	always @*
	begin
		rdata_d = reg_rdata_o;
		if (reg_rd_i)
		begin
			// priority order is moot, the offsets are distinct
			if (sel_test_a)
				rdata_d = test_a;
			else if (sel_test_b)
				rdata_d = test_b;
			else if (sel_safety)
				rdata_d = safety;
			else
				rdata_d = 32'h00000000;
		end
	end

	// read data register; holds until the next read strobe
	always @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
			reg_rdata_o <= 32'h00000000;
		else
			reg_rdata_o <= rdata_d;
	end

	// outputs below are one gate from register bits, no extra latency
	// training timer, skip and compliance controls go straight out
	assign timer_test_mode_o = test_a[`PLTC_A_TIMER_LSB +: NPORT]; // RULE1
	assign skip_forced_o = test_a[`PLTC_A_SKIP_BIT]; // RULE2
	// fixed interval, so the ordered-set logic needs no interval register
	assign skip_forced_symbols_o = `PLTC_SKIP_FORCED_SYMBOLS; // RULE2
	assign ignore_compliance_rx_o = test_a[`PLTC_A_IGNCR_BIT]; // RULE3

	// bit 10 picks one loop point; both outputs are never high together
	assign analog_sel = test_a[`PLTC_A_ANALOG_BIT];
	assign near_end_serial_loop_o = test_b[`PLTC_B_NES_LSB +: NPORT]; // RULE7
	assign phy_interface_loop_point_o = test_b[`PLTC_B_PAR_LSB +: NPORT] & {NPORT{~analog_sel}}; // RULE8
	assign far_end_loop_point_o = test_b[`PLTC_B_PAR_LSB +: NPORT] & {NPORT{analog_sel}}; // RULE8

	// bit n drives pair n: quad n/2, lower pair when n even
	// gated by master state, so a stray enable sends nothing on a normal link
	assign user_pattern_generator_o = test_b[`PLTC_B_UTP_LSB +: NPAIR] & pair_loop_master_i; // RULE9 RULE10

	// disable bit is active high, advertisement active high
	assign upconfig_advertise_o = ~safety[`PLTC_S_UPCFG_BIT]; // RULE13

	// entry needs two loopback-only sets on consecutive cycles
	assign slave_active = digital_loop_slave_o | analog_loop_slave_o;
	// a slave port ignores further sets until it exits
	assign slave_entry = ts1_seen_q & ts1_loopback_only_i & ~slave_active; // RULE4

	// next slave state; exit wins over a set arriving in the same cycle
	always @*
	begin
		digital_slave_d = digital_loop_slave_o;
		analog_slave_d = analog_loop_slave_o;
		codec_128b_d = loop_codec_128b_o;
		// ports are independent of each other
		for (i = 0; i < NPORT; i = i + 1)
		begin
			if (loop_slave_exit_i[i])
			begin
				digital_slave_d[i] = 1'b0;
				analog_slave_d[i] = 1'b0;
			end
			else if (slave_entry[i])
			begin
				digital_slave_d[i] = ~analog_sel; // RULE4
				analog_slave_d[i] = analog_sel; // RULE6
				codec_128b_d[i] = port_is_gen3_i[i]; // RULE5
			end
		end
	end

	// mode latches at entry, so a later bit 10 change waits for exit;
	// the codec flag stays as is on exit and means nothing outside loopback
	always @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
		begin
			ts1_seen_q <= {NPORT{1'b0}};
			digital_loop_slave_o <= {NPORT{1'b0}};
			analog_loop_slave_o <= {NPORT{1'b0}};
			loop_codec_128b_o <= {NPORT{1'b0}};
		end
		else
		begin
			// last cycle's set, paired with this cycle's
			ts1_seen_q <= ts1_loopback_only_i;
			digital_loop_slave_o <= digital_slave_d;
			analog_loop_slave_o <= analog_slave_d;
			loop_codec_128b_o <= codec_128b_d;
		end
	end
endmodule // pltc_phy_test_ctrl
`default_nettype wire

/* verification/pltc_assertions.sv */
// port-level checks on the phy test control bank
`timescale 1ns/100ps
`default_nettype none
module pltc_assertions #(
	parameter NPORT = 4,
	parameter NPAIR = 8
) (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic reg_wr_i,
	input wire logic [11:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic [NPORT-1:0] timer_test_mode_o,
	input wire logic skip_forced_o,
	input wire logic ignore_compliance_rx_o,
	input wire logic upconfig_advertise_o,
	input wire logic [NPORT-1:0] phy_interface_loop_point_o,
	input wire logic [NPORT-1:0] far_end_loop_point_o,
	input wire logic [NPAIR-1:0] pair_loop_master_i,
	input wire logic [NPAIR-1:0] user_pattern_generator_o,
	input wire logic [NPORT-1:0] ts1_loopback_only_i,
	input wire logic [NPORT-1:0] loop_slave_exit_i,
	input wire logic [NPORT-1:0] digital_loop_slave_o,
	input wire logic [NPORT-1:0] analog_loop_slave_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);
	// write of the first test word, and two back-to-back loopback sets on port 0
	sequence s_wa; reg_wr_i && reg_addr_i == 12'h224; endsequence
	sequence s_two; ts1_loopback_only_i[0] ##1 (ts1_loopback_only_i[0] && !loop_slave_exit_i[0]); endsequence
	property p_tim; s_wa |=> timer_test_mode_o == $past(reg_wdata_i[3:0]); endproperty
	a_tim: assert property (p_tim) else $error("timer mode wrong");
	property p_hld; !(reg_wr_i && reg_addr_i == 12'h224) |=> $stable(timer_test_mode_o); endproperty
	a_hld: assert property (p_hld) else $error("timer mode moved");
	property p_skp; s_wa |=> skip_forced_o == $past(reg_wdata_i[8]); endproperty
	a_skp: assert property (p_skp) else $error("skip force wrong");
	property p_ign; s_wa |=> ignore_compliance_rx_o == $past(reg_wdata_i[9]); endproperty
	a_ign: assert property (p_ign) else $error("ignore bit wrong");
	property p_upc; reg_wr_i && reg_addr_i == 12'h22C |=> upconfig_advertise_o == !$past(reg_wdata_i[6]); endproperty
	a_upc: assert property (p_upc) else $error("upconfig wrong");
	property p_ugp; (user_pattern_generator_o & ~pair_loop_master_i) == 8'h00; endproperty
	a_ugp: assert property (p_ugp) else $error("pattern without master");
	property p_fep; (far_end_loop_point_o & phy_interface_loop_point_o) == 4'h0; endproperty
	a_fep: assert property (p_fep) else $error("two loop points");
	property p_lb; s_two |=> digital_loop_slave_o[0] || analog_loop_slave_o[0]; endproperty
	a_lb: assert property (p_lb) else $error("no loop slave");
endmodule // pltc_assertions
bind pltc_phy_test_ctrl pltc_assertions #(.NPORT(NPORT), .NPAIR(NPAIR)) u_chk (.clk_sys_i, .sys_rst_i, .reg_wr_i,
	.reg_addr_i, .reg_wdata_i, .timer_test_mode_o, .skip_forced_o, .ignore_compliance_rx_o, .upconfig_advertise_o,
	.phy_interface_loop_point_o, .far_end_loop_point_o, .pair_loop_master_i, .user_pattern_generator_o,
	.ts1_loopback_only_i, .loop_slave_exit_i, .digital_loop_slave_o, .analog_loop_slave_o);
`default_nettype wire

/* verification/pltc_link_partner.sv */
// link partner model: loopback-only training sets and loopback exit
`timescale 1ns/100ps
`default_nettype none
module pltc_link_partner (
	input wire logic clk_sys_i,
	output logic [3:0] ts1_o,
	output logic [3:0] exit_o
);
	initial ts1_o = 4'h0;
	initial exit_o = 4'h0;
	// exit is one cycle, entry is two consecutive sets
	task send(input int p, input bit ex);
		@(posedge clk_sys_i) #1;
		if (ex) exit_o[p] = 1'b1; else ts1_o[p] = 1'b1;
		repeat (ex ? 1 : 2) @(posedge clk_sys_i);
		#1 ts1_o = 4'h0;
		exit_o = 4'h0;
	endtask
endmodule // pltc_link_partner
`default_nettype wire

/* verification/tb_pltc_phy_test_ctrl.sv */
// self-checking bench for the phy test control bank
`timescale 1ns/100ps
`default_nettype none
module tb_pltc_phy_test_ctrl;
	logic clk_sys_i = 1'b0, sys_rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
	logic [11:0] reg_addr_i = 12'h000;
	logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o;
	logic [3:0] timer_test_mode_o, near_end_serial_loop_o, phy_interface_loop_point_o, far_end_loop_point_o;
	logic [3:0] digital_loop_slave_o, analog_loop_slave_o, loop_codec_128b_o, ts1_loopback_only_i, loop_slave_exit_i;
	logic [3:0] port_is_gen3_i = 4'h0;
	logic [7:0] pair_loop_master_i = 8'h00, user_pattern_generator_o;
	logic [8:0] skip_forced_symbols_o;
	logic skip_forced_o, ignore_compliance_rx_o, upconfig_advertise_o;
	int err_total = 0, samples_checked = 0, cyc = 0;
	pltc_phy_test_ctrl dut (.clk_sys_i, .sys_rst_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o,
		.timer_test_mode_o, .skip_forced_o, .skip_forced_symbols_o, .ignore_compliance_rx_o, .ts1_loopback_only_i,
		.port_is_gen3_i, .loop_slave_exit_i, .digital_loop_slave_o, .analog_loop_slave_o, .loop_codec_128b_o,
		.near_end_serial_loop_o, .phy_interface_loop_point_o, .far_end_loop_point_o, .pair_loop_master_i,
		.user_pattern_generator_o, .upconfig_advertise_o);
	pltc_link_partner lp (.clk_sys_i, .ts1_o(ts1_loopback_only_i), .exit_o(loop_slave_exit_i));
	initial forever #20 clk_sys_i = ~clk_sys_i;
	// compare, write and read helpers; strobes held one full cycle
	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) $display("Error t=%0t got %h exp %h", $time, got, exp);
		if (got !== exp) err_total++;
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys_i) #1 reg_wr_i = 1'b1;
		reg_addr_i = a;
		reg_wdata_i = d;
		@(posedge clk_sys_i) #1 reg_wr_i = 1'b0;
	endtask
	task rd(input logic [11:0] a, input logic [31:0] e);
		@(posedge clk_sys_i) #1 reg_rd_i = 1'b1;
		reg_addr_i = a;
		@(posedge clk_sys_i) #1 reg_rd_i = 1'b0;
		chk(reg_rdata_o, e);
	endtask
	task close_out;
		$display("checks %0d errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// hang guard, well past the fifty or so cycles the tests need
	always @(posedge clk_sys_i)
	begin
		cyc++;
		if (cyc == 3000) err_total++;
		if (cyc == 3000) close_out;
	end
	initial
	begin
		repeat (5) @(posedge clk_sys_i);
		#1 sys_rst_i = 1'b0;
		rd(12'h224, 32'h0);
		rd(12'h228, 32'h0);
		rd(12'h22C, 32'hF0000000);
		chk(upconfig_advertise_o, 1);
		wr(12'h224, 32'hFFFFFFFF);
		rd(12'h224, 32'h000FFF0F);
		chk({ignore_compliance_rx_o, skip_forced_o, timer_test_mode_o}, 6'h3F);
		chk(skip_forced_symbols_o, 9'h100);
		pair_loop_master_i = 8'h81;
		wr(12'h228, 32'hFFFFFFFF);
		rd(12'h228, 32'hFF0F0FFF);
		chk({near_end_serial_loop_o, far_end_loop_point_o, phy_interface_loop_point_o}, 12'hFF0);
		chk(user_pattern_generator_o, 8'h81);
		$display("test registers done");
		lp.send(1, 0);
		@(posedge clk_sys_i) #1 chk({digital_loop_slave_o, analog_loop_slave_o}, 8'h02);
		lp.send(1, 1);
		@(posedge clk_sys_i) #1 chk(analog_loop_slave_o, 0);
		wr(12'h224, 32'h0);
		port_is_gen3_i = 4'h1;
		chk({far_end_loop_point_o, phy_interface_loop_point_o}, 8'h0F);
		lp.send(0, 0);
		@(posedge clk_sys_i) #1 chk({digital_loop_slave_o, loop_codec_128b_o}, 8'h11);
		lp.send(0, 1);
		lp.send(2, 0);
		@(posedge clk_sys_i) #1 chk({digital_loop_slave_o, loop_codec_128b_o}, 8'h41);
		$display("test loopback done");
		wr(12'h22C, 32'hFFFFFFFF);
		rd(12'h22C, 32'hFFFFFFFF);
		chk(upconfig_advertise_o, 0);
		wr(12'h230, 32'hFFFFFFFF);
		rd(12'h230, 32'h0);
		$display("test safety done");
		close_out;
	end
endmodule // tb_pltc_phy_test_ctrl
`default_nettype wire
